// ---- logic/sg_amp_pwm.sv ----
`timescale 1ns/1ps
module sg_amp_pwm
    import sg_pkg::*;
(
    // clock and reset
    input  wire logic                i_clk,
    input  wire logic                i_sys_rst,
    // control
    input  wire logic                i_run,
    input  wire logic [SG_VOL_W-1:0] i_volume_level,
    input  wire logic [SG_VOL_W-1:0] i_count,
    // output
    output logic                     o_pwm
);

    logic next_pwm;

    // code 0 never high; code n high for n+1 of 128 counts
    assign next_pwm = i_run && (i_volume_level != '0) && (i_count <= i_volume_level); // [R17] [R19]

    // level taken live: a rewrite mid-period may stretch one high phase
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
            o_pwm <= 1'b0;
        else
            o_pwm <= next_pwm; // [R2] [R18]
    end

endmodule // sg_amp_pwm

// ---- logic/sg_pkg.sv ----
package sg_pkg;

    // register addresses
    localparam logic [15:0] SG_ADDR_CONTROL = 16'hffc0;
    localparam logic [15:0] SG_ADDR_VOLUME  = 16'hffc1;
    localparam logic [15:0] SG_ADDR_DIVISOR = 16'hffc2;

    // reset values
    localparam logic [7:0] SG_CONTROL_RST = 8'h00;
    localparam logic [7:0] SG_DIVISOR_RST = 8'h00;
    localparam logic [7:0] SG_VOLUME_RST  = 8'h00;

    // control field positions
    localparam int SG_CTL_RUN     = 7;
    localparam int SG_CTL_OUTSEL  = 3;
    localparam int SG_CTL_CNTSEL  = 1;
    localparam int SG_CTL_INSEL   = 0;

    // widths
    localparam int SG_PRE_W = 8;
    localparam int SG_TON_W = 5;
    localparam int SG_DIV_W = 4;
    localparam int SG_VOL_W = 7;

    // tone half period in counter-clock ticks is divisor + this offset
    localparam logic [SG_TON_W-1:0] SG_TONE_OFFSET = 5'h11;
    // smallest counter-clock divide is 2^5
    localparam int SG_CNT_SHIFT_BASE = 5;

    // register access request from the cpu side
    typedef struct packed {
        logic        wr;
        logic        bit_wr;
        logic        rd;
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic [2:0]  bit_idx;
        logic        bit_val;
    } sg_reg_req_t;

    // pin-side outputs
    typedef struct packed {
        logic tone;
        logic amplitude;
        logic amp_released;
    } sg_pins_t;

endpackage

// ---- logic/sg_tone_gen.sv ----
`timescale 1ns/1ps
//Behaviour
// R1 - volume tone is tone ANDed with PWM
// R2 - independent 7-bit amplitude PWM output
// R3 - one 8-bit and one 5-bit counter
// R4 - control resets 00H, bit or byte writes
// R5 - run bit clear stops counters, outputs low; amp_released still follows bit 3 while stopped
// R6 - software sets other bits before run bit
// R7 - bit 3 selects plain or volume tone
// R8 - bits 2:1 pick divide 2^5 to 2^8
// R9 - bit 0 picks main clock or half
// R10 - software stops generator before control rewrite
// R11 - software writes zero to control bits 6:4
// R12 - tone frequency scales with divisor plus 17
// R13 - divisor resets 00H, byte writes only
// R14 - larger divisor code gives lower tone
// R15 - software stops generator before divisor rewrite
// R16 - software writes zero to divisor bits 7:4
// R17 - amplitude duty (n+1)/128, zero gives none
// R18 - amplitude may change while running
// R19 - amplitude compares against free-running count
module sg_tone_gen
    import sg_pkg::*;
(
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    // register access
    input  wire sg_reg_req_t i_req,
    output logic [7:0]       o_rdata,
    output logic             o_rvalid,
    // pins
    output sg_pins_t         o_pins
);

    // registers
    logic                run_bit;
    logic                output_select_bit;
    logic [1:0]          counter_clock_select;
    logic                input_clock_select;
    logic [SG_DIV_W-1:0] tone_divisor;
    logic [SG_VOL_W-1:0] volume_level;

    // datapath
    logic                half_phase;
    logic [SG_PRE_W-1:0] prescale_count;
    logic [SG_TON_W-1:0] tone_count;
    logic                tone_level;
    logic                pwm_level;

    // decode
    wire hit_control = i_req.addr == SG_ADDR_CONTROL;
    wire hit_volume  = i_req.addr == SG_ADDR_VOLUME;
    wire hit_divisor = i_req.addr == SG_ADDR_DIVISOR;

    wire [7:0] control_image = {run_bit, 3'h0, output_select_bit,
                                counter_clock_select, input_clock_select};

    function automatic logic [7:0] merge_bit(input logic [7:0] cur, input logic [2:0] idx,
                                              input logic val);
        logic [7:0] res;
        res      = cur;
        res[idx] = val;
        return res;
    endfunction

    // control write value for both byte and bit writes
    wire [7:0] control_wval = i_req.bit_wr
        ? merge_bit(control_image, i_req.bit_idx, i_req.bit_val)
        : i_req.wdata; // [R4]
    wire       control_we   = hit_control && (i_req.wr || i_req.bit_wr);

    wire       divisor_we   = hit_divisor && i_req.wr;
    wire       volume_we    = hit_volume && i_req.wr;

    logic [7:0] read_mux;

    // read-back decode; unmapped addresses read zero
    always_comb
    begin
        if (hit_control)
            read_mux = control_image;
        else if (hit_volume)
            read_mux = {1'b0, volume_level};
        else if (hit_divisor)
            read_mux = {4'h0, tone_divisor};
        else
            read_mux = 8'h00;
    end

    // control fields; unused bits 6:4 are not stored and read zero
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            run_bit              <= SG_CONTROL_RST[SG_CTL_RUN]; // [R4]
            output_select_bit    <= SG_CONTROL_RST[SG_CTL_OUTSEL];
            counter_clock_select <= SG_CONTROL_RST[SG_CTL_CNTSEL +: 2];
            input_clock_select   <= SG_CONTROL_RST[SG_CTL_INSEL];
        end
        else if (control_we)
        begin
            run_bit              <= control_wval[SG_CTL_RUN];
            output_select_bit    <= control_wval[SG_CTL_OUTSEL];
            counter_clock_select <= control_wval[SG_CTL_CNTSEL +: 2];
            input_clock_select   <= control_wval[SG_CTL_INSEL];
        end
    end

    // divisor is not guarded by run: software must stop first
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
            tone_divisor <= SG_DIVISOR_RST[SG_DIV_W-1:0]; // [R13]
        else if (divisor_we)
            tone_divisor <= i_req.wdata[SG_DIV_W-1:0]; // [R13]
    end

    // volume may be rewritten while running
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
            volume_level <= SG_VOLUME_RST[SG_VOL_W-1:0]; // [R17]
        else if (volume_we)
            volume_level <= i_req.wdata[SG_VOL_W-1:0]; // [R18]
    end

    // read answer stands one cycle
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
            o_rvalid <= 1'b0;
        else
            o_rvalid <= i_req.rd;
    end

    // data held at zero between answers
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
            o_rdata <= 8'h00;
        else if (i_req.rd)
            o_rdata <= read_mux;
        else
            o_rdata <= 8'h00;
    end

    // generator input clock enable: every cycle or every other
    wire gen_tick = input_clock_select | half_phase; // [R9]

    // counter clock tick when the low 5..8 prescaler bits all wrap
    function automatic logic low_bits_full(input logic [SG_PRE_W-1:0] cnt,
                                           input logic [1:0] sel);
        logic [SG_PRE_W-1:0] mask;
        mask = SG_PRE_W'((1 << (SG_CNT_SHIFT_BASE + int'(sel))) - 1);
        return (cnt & mask) == mask;
    endfunction

    wire cnt_tick  = gen_tick && low_bits_full(prescale_count, counter_clock_select); // [R8]
    wire [SG_TON_W-1:0] tone_last = {1'b0, tone_divisor} + SG_TONE_OFFSET - 5'h01; // [R12]
    wire tone_wrap = tone_count == tone_last;

    // stopped generator clears every counter so a restart is clean
    wire gen_stop  = i_sys_rst || !run_bit; // [R5]

    always_ff @(posedge i_clk)
    begin
        if (gen_stop)
            half_phase <= 1'b0; // [R5]
        else
            half_phase <= ~half_phase;
    end

    // 8-bit prescaler also feeds the pwm compare
    always_ff @(posedge i_clk)
    begin
        if (gen_stop)
            prescale_count <= '0;
        else if (gen_tick)
            prescale_count <= prescale_count + 8'h01; // [R3]
    end

    // 5-bit tone counter toggles the level on each wrap
    always_ff @(posedge i_clk)
    begin
        if (gen_stop)
        begin
            tone_count <= '0;
            tone_level <= 1'b0;
        end
        else if (cnt_tick)
        begin
            // half period of divisor+17 ticks, larger code is slower
            tone_count <= tone_wrap ? '0 : tone_count + 5'h01; // [R3] [R14]
            if (tone_wrap)
                tone_level <= ~tone_level; // [R12]
        end
    end

    // pwm count shares the free-running prescaler low bits
    sg_amp_pwm u_amp_pwm (
        .i_clk          (i_clk),
        .i_sys_rst      (i_sys_rst),
        .i_run          (run_bit),
        .i_volume_level (volume_level),
        .i_count        (prescale_count[SG_VOL_W-1:0]),
        .o_pwm          (pwm_level)
    );

    // output stage registered; stopped generator drives tone and amplitude low
    wire next_tone = run_bit && (output_select_bit ? (tone_level & pwm_level)
                                                   : tone_level); // [R1] [R7] [R5]
    wire next_amp  = run_bit && !output_select_bit && pwm_level; // [R2] [R7]
    // released pin is left to the clock-out mux, acts as active-low enable
    wire next_released = output_select_bit; // [R7]

    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
            o_pins <= '0;
        else
        begin
            o_pins.tone         <= next_tone;
            o_pins.amplitude    <= next_amp;
            o_pins.amp_released <= next_released; // [R7]
        end
    end

endmodule // sg_tone_gen

// ---- verification/sg_speaker_model.sv ----
`timescale 1ns/1ps
module sg_speaker_model (
    // speaker side
    input  wire logic        i_clk,
    input  wire logic        i_tone,
    // measured tone
    output logic [15:0]      o_half,
    output logic [15:0]      o_edges
);
    logic [15:0] run_len = 16'h0000;
    logic        last    = 1'b0;
    initial o_half = 16'h0000;
    initial o_edges = 16'h0000;
    // a speaker only hears level changes, so each level's length is a half period
    always @(posedge i_clk)
    begin
        run_len <= (i_tone != last) ? 16'h0001 : run_len + 16'h0001;
        o_half <= (i_tone != last) ? run_len : o_half;
        o_edges <= o_edges + 16'(i_tone != last);
        last <= i_tone;
    end
endmodule // sg_speaker_model

// ---- verification/sg_tone_gen_sva.sv ----
`timescale 1ns/1ps
module sg_tone_gen_sva
    import sg_pkg::*;
(
    // watched ports
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    input  wire sg_reg_req_t i_req,
    input  wire logic [7:0]  o_rdata,
    input  wire logic        o_rvalid,
    input  wire sg_pins_t    o_pins
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    wire rd_on = i_req.rd;
    sequence s_ctl_wr;
        i_req.wr && !i_req.bit_wr && i_req.addr == SG_ADDR_CONTROL;
    endsequence
    sequence s_stop;
        s_ctl_wr ##0 !i_req.wdata[SG_CTL_RUN];
    endsequence
    rd_answer_a: assert property (rd_on |=> o_rvalid) else $error("no read answer");
    rd_idle_a: assert property (!rd_on |=> !o_rvalid && o_rdata == 8'h00)
        else $error("stray read data");
    ctl_pad_a: assert property (rd_on && i_req.addr == SG_ADDR_CONTROL |=>
        o_rdata[6:4] == 3'h0) else $error("control pad bits");
    div_pad_a: assert property (rd_on && i_req.addr == SG_ADDR_DIVISOR |=>
        o_rdata[7:4] == 4'h0) else $error("divisor pad bits");
    stop_low_a: assert property (s_stop |-> ##2 !o_pins.tone && !o_pins.amplitude)
        else $error("pins not low after stop");
    rel_low_a: assert property (o_pins.amp_released |-> !o_pins.amplitude)
        else $error("amplitude while released");
    sel_follow_a: assert property (s_ctl_wr ##1 (!i_req.wr && !i_req.bit_wr)[*2] |->
        o_pins.amp_released == $past(i_req.wdata[SG_CTL_OUTSEL], 2)) else $error("select");
    rst_clear_a: assert property (disable iff (1'b0) i_sys_rst |=>
        !o_pins.tone && !o_pins.amplitude && !o_rvalid) else $error("reset outputs");
endmodule // sg_tone_gen_sva

// ---- verification/sg_tone_gen_test.sv ----
`timescale 1ns/1ps
module sg_tone_gen_test;
    import sg_pkg::*;
    logic        i_clk = 1'b0;
    logic        i_sys_rst = 1'b1;
    sg_reg_req_t req = '0;
    logic [7:0]  o_rdata;
    logic        o_rvalid;
    sg_pins_t    o_pins;
    logic [15:0] half, edges, d, e0, hi;
    logic [7:0]  exp_q[$];
    logic [7:0]  codes[4];
    int          miscompares = 0;
    int          cmp_count = 0;
    logic        s, b0;
    always #2 i_clk = ~i_clk;
    sg_tone_gen sg_tone_gen_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_req(req),
        .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_pins(o_pins));
    sg_speaker_model sg_speaker_model_inst (.i_clk(i_clk), .i_tone(o_pins.tone),
        .o_half(half), .o_edges(edges));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // kind: 1 byte write, 2 bit write (index in v[2:0], value in v[7]), 4 read
    task automatic acc(input logic [2:0] k, input logic [15:0] a, input logic [7:0] v);
        @(posedge i_clk);
        req <= '{wr:k[0], bit_wr:k[1], rd:k[2], addr:a, wdata:v, bit_idx:v[2:0], bit_val:v[7]};
        @(posedge i_clk);
        req <= '0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        acc(3'h4, a, 8'h00);
    endtask
    task automatic two_edges;
        e0 = edges;
        for (int n = 0; n < 20000 && edges < e0 + 16'h0002; n++) @(posedge i_clk);
    endtask
    always @(posedge i_clk)
        if (o_rvalid === 1'b1) check(16'(o_rdata), 16'(exp_q.pop_front()));
    initial
    begin
        #(4 * 90000);
        miscompares++;
        complete_run();
    end
    initial
    begin
        void'($urandom(32'h0000_0d4d));
        repeat (20) @(posedge i_clk);
        i_sys_rst <= 1'b0;
        rd(SG_ADDR_CONTROL, 8'h00);
        rd(SG_ADDR_VOLUME, 8'h00);
        rd(SG_ADDR_DIVISOR, 8'h00);
        // pad bits written on purpose to see them dropped
        acc(3'h1, SG_ADDR_CONTROL, 8'h7f);
        rd(SG_ADDR_CONTROL, 8'h0f);
        acc(3'h1, SG_ADDR_DIVISOR, 8'hff);
        rd(SG_ADDR_DIVISOR, 8'h0f);
        acc(3'h1, SG_ADDR_VOLUME, 8'hff);
        rd(SG_ADDR_VOLUME, 8'h7f);
        acc(3'h1, 16'hffc3, 8'hff);
        rd(16'hffc3, 8'h00);
        acc(3'h1, SG_ADDR_CONTROL, 8'h00);
        acc(3'h2, SG_ADDR_CONTROL, 8'h83);
        rd(SG_ADDR_CONTROL, 8'h08);
        repeat (4)
        begin
            d = 16'($urandom % 16);
            s = 1'($urandom % 2);
            b0 = 1'($urandom % 2);
            acc(3'h1, SG_ADDR_CONTROL, 8'h00);
            acc(3'h1, SG_ADDR_DIVISOR, {4'h0, d[3:0]});
            acc(3'h1, SG_ADDR_CONTROL, {6'h00, s, b0});
            acc(3'h1, SG_ADDR_CONTROL, {6'h20, s, b0});
            two_edges();
            check(half, (d + 16'h0011) << (5 + s + !b0));
        end
        codes = '{8'h00, 8'h01, 8'($urandom % 128), 8'h7f};
        acc(3'h1, SG_ADDR_CONTROL, 8'h00);
        acc(3'h1, SG_ADDR_CONTROL, 8'h81);
        foreach (codes[i])
        begin
            acc(3'h1, SG_ADDR_VOLUME, codes[i]);
            repeat (130) @(posedge i_clk);
            hi = 16'h0000;
            repeat (256) @(posedge i_clk) hi += 16'(o_pins.amplitude);
            check(hi, codes[i] == 0 ? 16'h0000 : 16'(codes[i] + 1) << 1);
        end
        acc(3'h1, SG_ADDR_CONTROL, 8'h00);
        acc(3'h1, SG_ADDR_DIVISOR, 8'h00);
        acc(3'h1, SG_ADDR_VOLUME, 8'h00);
        acc(3'h1, SG_ADDR_CONTROL, 8'h09);
        acc(3'h1, SG_ADDR_CONTROL, 8'h89);
        hi = 16'h0000;
        repeat (1200) @(posedge i_clk) hi += 16'(o_pins.tone);
        check(hi, 16'h0000);
        acc(3'h1, SG_ADDR_VOLUME, 8'h7f);
        two_edges();
        check(half, 16'h0220);
        acc(3'h1, SG_ADDR_CONTROL, 8'h00);
        repeat (3) @(posedge i_clk);
        check(16'(o_pins), 16'h0000);
        complete_run();
    end
endmodule // sg_tone_gen_test
bind sg_tone_gen sg_tone_gen_sva sg_tone_gen_sva_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .i_req(i_req), .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_pins(o_pins));
